// [rtl/trs_pkg.sv]
// package for the radio transmit scheduler: settings, limits, codes and cycle counts
// assumes a 25 MHz system clock and a one-pulse-per-second input marking each UTC second
//
// What this block does
// [RULE1] own station identifier must lie in 1..65501, else configuration is rejected
// [RULE2] repeaters decrement hop limit; zero stops forwarding; value 7 disables limiting
// [RULE3] destination field inserted in local packets only when its option is on
// [RULE4] with path tracing on, a repeater appends its own identifier to relayed packets
// [RULE5] correction mode 0 strongest, 1 medium, 2 weakest with highest throughput
// [RULE6] slotted with good clock sends only in own slot, else at random times
// [RULE7] slotted mode off means random access and readings carry no time stamp
// [RULE8] frame length 5000..3600000 ms in 250 ms steps
// [RULE9] frame length must divide twelve hours exactly
// [RULE10] slot length 250..10000 ms
// [RULE11] a report that overruns the slot end is allowed to finish
// [RULE12] slot starts at a configured ms offset from each frame start
// [RULE13] padding interval, default 25 ms, between slot start and earliest transmission
// [RULE14] if the slot cannot be assured, fall back to random times and flag clock status
// [RULE15] centering places transmission midpoint at slot midpoint, never before padding
// [RULE16] with centering, a transmission longer than the slot still goes and overruns
// [RULE17] without centering, carrier starts exactly when the padding expires
// [RULE18] power mode selects when radio supply is on; default only with data waiting
// [RULE19] supply applied for warm-up time, default 750 ms, before transmission
// [RULE20] unmodulated carrier for configured time, default 5 ms, before modulation
// [RULE21] tone-modulated carrier next for settling time, default 55 ms
// [RULE22] unmodulated tail, default 5 ms, after data before releasing the radio
// [RULE23] keying phases run strictly in order, each starting when the previous expires
// [RULE24] frame and slot timing come from a ms counter aligned by the second pulse

package trs_pkg;

	// clock and millisecond tick
	localparam int CLK_HZ = 25000000;
	localparam int MS_PER_S = 1000;
	localparam int CYC_PER_MS = CLK_HZ / MS_PER_S;

	// identifier range
	localparam logic [15:0] SRC_ID_MIN = 16'h0001;
	localparam logic [15:0] SRC_ID_MAX = 16'hFFDD; // 65501

	// hop limit
	localparam logic [2:0] HOP_UNLIMITED = 3'h7;
	localparam logic [2:0] HOP_EXPIRED = 3'h0;

	// correction strength codes
	localparam logic [1:0] FEC_STRONG = 2'h0;
	localparam logic [1:0] FEC_MEDIUM = 2'h1;
	localparam logic [1:0] FEC_WEAK = 2'h2;

	// frame and slot limits in ms
	localparam logic [21:0] FRAME_MIN_MS = 22'h001388; // 5000
	localparam logic [21:0] FRAME_MAX_MS = 22'h36EE80; // 3600000
	localparam logic [21:0] FRAME_STEP_MS = 22'h0000FA; // 250
	localparam logic [25:0] HALF_DAY_MS = 26'h2932E00; // 43200000
	localparam logic [13:0] SLOT_MIN_MS = 14'h00FA; // 250
	localparam logic [13:0] SLOT_MAX_MS = 14'h2710; // 10000

	// reset values of the settings
	localparam logic [15:0] RST_SRC_ID = 16'h03E8; // 1000
	localparam logic [21:0] RST_FRAME_MS = 22'h003A98; // 15000
	localparam logic [13:0] RST_SLOT_MS = 14'h03E8; // 1000
	localparam logic [15:0] RST_PAD_MS = 16'h0019; // 25
	localparam logic [15:0] RST_WARM_MS = 16'h02EE; // 750
	localparam logic [15:0] RST_CARR_MS = 16'h0005;
	localparam logic [15:0] RST_TONE_MS = 16'h0037; // 55
	localparam logic [15:0] RST_TAIL_MS = 16'h0005;

	// radio power modes
	localparam logic [1:0] PWR_WITH_DATA = 2'h0;
	localparam logic [1:0] PWR_ALWAYS = 2'h1;

	// register offsets (word index of the plain port)
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_SRC = 4'h1;
	localparam logic [3:0] REG_FRAME = 4'h2;
	localparam logic [3:0] REG_SLOT = 4'h3;
	localparam logic [3:0] REG_OFFSET = 4'h4;
	localparam logic [3:0] REG_PAD = 4'h5;
	localparam logic [3:0] REG_WARM = 4'h6;
	localparam logic [3:0] REG_CARR = 4'h7;
	localparam logic [3:0] REG_TONE = 4'h8;
	localparam logic [3:0] REG_TAIL = 4'h9;
	localparam logic [3:0] REG_STATUS = 4'hA;

	// control register fields
	localparam int CTRL_HOP_LSB = 0;
	localparam int CTRL_FEC_LSB = 3;
	localparam int CTRL_DST_BIT = 5;
	localparam int CTRL_PATH_BIT = 6;
	localparam int CTRL_SLOTTED_BIT = 7;
	localparam int CTRL_CENTER_BIT = 8;
	localparam int CTRL_PWR_LSB = 9;
	localparam logic [10:0] RST_CTRL = 11'h0C1; // hop 1, path on, slotted on

	// keying phases
	typedef enum logic [6:0] {
		PH_IDLE = 7'h01,
		PH_WARM = 7'h02,
		PH_WAIT = 7'h04,
		PH_CARR = 7'h08,
		PH_TONE = 7'h10,
		PH_DATA = 7'h20,
		PH_TAIL = 7'h40
	} trs_phase_e;

endpackage

// [rtl/trs_scheduler.sv]
// transmit scheduler with frame and slot timing, forwarding options and radio keying
// assumes pps and the clock-good level come from outside this clock domain; data
// handshake signals come from the encoder on the same clock
//
// Our own choices: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

module trs_scheduler #(
	parameter int CYC_MS = trs_pkg::CYC_PER_MS
)(
	input wire logic clk_sys,
	input wire logic rst,
	// plain register port
	input wire logic [3:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// time base
	input wire logic pps,
	input wire logic clock_good,
	input wire logic [15:0] rand_ms,
	// encoder side
	input wire logic tx_pending,
	input wire logic [15:0] tx_len_ms,
	input wire logic data_done,
	output logic data_go,
	// packet forwarding
	input wire logic fwd_remote,
	input wire logic [2:0] fwd_hop_in,
	output logic fwd_allow,
	output logic [2:0] fwd_hop_out,
	output logic fwd_append_id,
	output logic [15:0] own_src_id,
	output logic add_dest,
	output logic stamp_readings,
	output logic [1:0] fec_mode,
	// radio
	output logic radio_pwr,
	output logic radio_key,
	output logic radio_tone,
	output logic clock_status
);

	// ==========================================================
	// settings registers
	logic [10:0] ctrl_r;
	logic [15:0] src_r;
	logic [21:0] frame_r;
	logic [13:0] slot_r;
	logic [21:0] offs_r;
	logic [15:0] pad_r;
	logic [15:0] warm_r;
	logic [15:0] carr_r;
	logic [15:0] tone_r;
	logic [15:0] tail_r;
	logic rej_r;

	wire [2:0] hop_cfg = ctrl_r[trs_pkg::CTRL_HOP_LSB +: 3];
	wire slotted = ctrl_r[trs_pkg::CTRL_SLOTTED_BIT];
	wire center = ctrl_r[trs_pkg::CTRL_CENTER_BIT];
	wire [1:0] pwr_mode = ctrl_r[trs_pkg::CTRL_PWR_LSB +: 2];

	// write-side validation; a rejected value leaves the old one in place
	wire [15:0] w16 = reg_wdata[15:0];
	wire [21:0] w22 = reg_wdata[21:0];
	wire [25:0] w26 = {4'h0, w22};
	wire src_ok = (reg_wdata[31:16] == 16'h0000) && (w16 >= trs_pkg::SRC_ID_MIN)
		&& (w16 <= trs_pkg::SRC_ID_MAX); // see [RULE1]
	wire frame_ok = (reg_wdata[31:22] == 10'h000) && (w22 >= trs_pkg::FRAME_MIN_MS)
		&& (w22 <= trs_pkg::FRAME_MAX_MS) && (w22 % trs_pkg::FRAME_STEP_MS == 22'h0)
		&& (w26 != 26'h0) && (trs_pkg::HALF_DAY_MS % w26 == 26'h0); // see [RULE8] see [RULE9]
	wire slot_ok = (reg_wdata[31:14] == 18'h0) && (reg_wdata[13:0] >= trs_pkg::SLOT_MIN_MS)
		&& (reg_wdata[13:0] <= trs_pkg::SLOT_MAX_MS); // see [RULE10]
	wire fec_ok = reg_wdata[trs_pkg::CTRL_FEC_LSB +: 2] <= trs_pkg::FEC_WEAK; // see [RULE5]
	wire offs_ok = w22 < frame_r;

	wire wr_ctrl = reg_wr && reg_addr == trs_pkg::REG_CTRL;
	wire wr_src = reg_wr && reg_addr == trs_pkg::REG_SRC;
	wire wr_frame = reg_wr && reg_addr == trs_pkg::REG_FRAME;
	wire wr_slot = reg_wr && reg_addr == trs_pkg::REG_SLOT;
	wire wr_offs = reg_wr && reg_addr == trs_pkg::REG_OFFSET;
	wire bad_wr = (wr_ctrl && !fec_ok) || (wr_src && !src_ok) || (wr_frame && !frame_ok)
		|| (wr_slot && !slot_ok) || (wr_offs && !offs_ok);

	// settings storage
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ctrl_r <= trs_pkg::RST_CTRL;
			src_r <= trs_pkg::RST_SRC_ID;
			frame_r <= trs_pkg::RST_FRAME_MS;
			slot_r <= trs_pkg::RST_SLOT_MS;
			offs_r <= 22'h0;
			pad_r <= trs_pkg::RST_PAD_MS;
			warm_r <= trs_pkg::RST_WARM_MS;
			carr_r <= trs_pkg::RST_CARR_MS;
			tone_r <= trs_pkg::RST_TONE_MS;
			tail_r <= trs_pkg::RST_TAIL_MS;
			rej_r <= 1'b0;
		end
		else
		begin
			if (wr_ctrl && fec_ok)
				ctrl_r <= reg_wdata[10:0];
			if (wr_src && src_ok)
				src_r <= w16; // see [RULE1]
			if (wr_frame && frame_ok)
				frame_r <= w22;
			if (wr_slot && slot_ok)
				slot_r <= reg_wdata[13:0];
			if (wr_offs && offs_ok)
				offs_r <= w22; // see [RULE12]
			if (reg_wr && reg_addr == trs_pkg::REG_PAD)
				pad_r <= w16;
			if (reg_wr && reg_addr == trs_pkg::REG_WARM)
				warm_r <= w16;
			if (reg_wr && reg_addr == trs_pkg::REG_CARR)
				carr_r <= w16;
			if (reg_wr && reg_addr == trs_pkg::REG_TONE)
				tone_r <= w16;
			if (reg_wr && reg_addr == trs_pkg::REG_TAIL)
				tail_r <= w16;
			// sticky reject flag; a new reject wins over the clear by status read
			if (bad_wr)
				rej_r <= 1'b1;
			else if (reg_rd && reg_addr == trs_pkg::REG_STATUS)
				rej_r <= 1'b0;
		end
	end

	// ==========================================================
	// millisecond time base aligned to the second pulse
	logic pps_s1_r;
	logic pps_s2_r;
	logic pps_d_r;
	logic good_s1_r;
	logic good_s2_r;
	logic [15:0] cyc_r;
	logic [21:0] fpos_r;
	logic [9:0] ms_in_s_r;

	wire pps_rise = pps_s2_r && !pps_d_r;
	wire ms_tick = cyc_r == 16'(CYC_MS - 1);
	wire [21:0] fpos_inc = (fpos_r + 22'h1 >= frame_r) ? 22'h0 : fpos_r + 22'h1;

	// the frame position advances per ms; the pulse rounds the ms within the second
	// so boundaries stay locked to the twelve-hour grid once time is set
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			pps_s1_r <= 1'b0;
			pps_s2_r <= 1'b0;
			pps_d_r <= 1'b0;
			good_s1_r <= 1'b0;
			good_s2_r <= 1'b0;
			cyc_r <= 16'h0;
			fpos_r <= 22'h0;
			ms_in_s_r <= 10'h0;
		end
		else
		begin
			pps_s1_r <= pps;
			pps_s2_r <= pps_s1_r;
			pps_d_r <= pps_s2_r;
			good_s1_r <= clock_good;
			good_s2_r <= good_s1_r;
			if (pps_rise)
			begin
				cyc_r <= 16'h0; // see [RULE24]
				ms_in_s_r <= 10'h0;
				// a pulse arriving early or late snaps to the nearest second edge
				if (ms_in_s_r != 10'h0)
					fpos_r <= (ms_in_s_r >= 10'd500)
						? ((fpos_r + 22'(1000 - ms_in_s_r) >= frame_r)
							? fpos_r + 22'(1000 - ms_in_s_r) - frame_r
							: fpos_r + 22'(1000 - ms_in_s_r))
						: ((fpos_r >= 22'(ms_in_s_r)) ? fpos_r - 22'(ms_in_s_r)
							: fpos_r + frame_r - 22'(ms_in_s_r));
			end
			else if (ms_tick)
			begin
				cyc_r <= 16'h0;
				fpos_r <= fpos_inc;
				ms_in_s_r <= (ms_in_s_r == 10'd999) ? 10'h0 : ms_in_s_r + 10'h1;
			end
			else
				cyc_r <= cyc_r + 16'h1;
		end
	end

	// ==========================================================
	// slot placement; the whole keyed time counts, not only the data, so the midpoint is true
	wire [17:0] tot_ms = {2'h0, tx_len_ms} + {2'h0, carr_r} + {2'h0, tone_r} + {2'h0, tail_r};
	wire [18:0] len_pad = {1'b0, tot_ms} + {3'h0, pad_r};
	wire [16:0] ctr_off = ({4'h0, slot_r} > tot_ms)
		? 17'(({4'h0, slot_r} - tot_ms) >> 1) : 17'h0;
	// centering never starts before the padding; long sends start at padding and overrun
	wire [16:0] start_off = (center && ctr_off > {1'b0, pad_r}) ? ctr_off
		: {1'b0, pad_r}; // see [RULE15] see [RULE16] see [RULE17] see [RULE13]
	wire [22:0] start_pos_raw = {1'b0, offs_r} + {6'h0, start_off};
	wire [22:0] start_pos = (start_pos_raw >= {1'b0, frame_r}) ? start_pos_raw - {1'b0, frame_r}
		: start_pos_raw;
	wire slot_fits = len_pad <= {3'h0, slot_r};
	// slot can be assured only with a good clock and padding shorter than the slot
	wire assured = good_s2_r && ({2'h0, pad_r} < {2'h0, slot_r}); // see [RULE14]
	wire use_slot = slotted && assured; // see [RULE6] see [RULE7]
	// fire as the start position begins, not as it ends, so the carrier meets the padding edge
	wire slot_hit = ms_tick && (fpos_inc == start_pos[21:0]); // see [RULE17]

	// ==========================================================
	// keying sequencer
	trs_pkg::trs_phase_e ph_r;
	trs_pkg::trs_phase_e ph_nxt;
	logic [15:0] tmr_r;
	logic [15:0] tmr_nxt;
	logic [15:0] rwait_r;
	logic [15:0] rwait_nxt;

	wire expired = ms_tick && (tmr_r <= 16'h1);
	wire fire = use_slot ? slot_hit : (ms_tick && rwait_r == 16'h0);

	// timed phases end when their timer expires or is set to zero; the wait ends on fire or on tx_pending low, data on data_done
	always_comb
	begin
		ph_nxt = ph_r;
		tmr_nxt = (ms_tick && tmr_r != 16'h0) ? tmr_r - 16'h1 : tmr_r;
		rwait_nxt = rwait_r;
		case (ph_r)
			trs_pkg::PH_IDLE:
			begin
				if (tx_pending)
				begin
					ph_nxt = trs_pkg::PH_WARM; // see [RULE18]
					tmr_nxt = warm_r;
				end
			end
			trs_pkg::PH_WARM:
			begin
				if (expired || warm_r == 16'h0)
				begin
					ph_nxt = trs_pkg::PH_WAIT; // see [RULE19]
					rwait_nxt = rand_ms;
				end
			end
			trs_pkg::PH_WAIT:
			begin
				if (ms_tick && rwait_r != 16'h0)
					rwait_nxt = rwait_r - 16'h1;
				if (!tx_pending)
					ph_nxt = trs_pkg::PH_IDLE;
				else if (fire)
				begin
					ph_nxt = trs_pkg::PH_CARR; // see [RULE23]
					tmr_nxt = carr_r;
				end
			end
			trs_pkg::PH_CARR:
			begin
				if (expired || carr_r == 16'h0)
				begin
					ph_nxt = trs_pkg::PH_TONE; // see [RULE20]
					tmr_nxt = tone_r;
				end
			end
			trs_pkg::PH_TONE:
			begin
				if (expired || tone_r == 16'h0)
					ph_nxt = trs_pkg::PH_DATA; // see [RULE21]
			end
			trs_pkg::PH_DATA:
			begin
				// data runs to its own end even past the slot boundary
				if (data_done)
				begin
					ph_nxt = trs_pkg::PH_TAIL; // see [RULE11]
					tmr_nxt = tail_r;
				end
			end
			trs_pkg::PH_TAIL:
			begin
				if (expired || tail_r == 16'h0)
					ph_nxt = trs_pkg::PH_IDLE; // see [RULE22]
			end
			default:
				ph_nxt = trs_pkg::PH_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ph_r <= trs_pkg::PH_IDLE;
			tmr_r <= 16'h0;
			rwait_r <= 16'h0;
		end
		else
		begin
			ph_r <= ph_nxt;
			tmr_r <= tmr_nxt;
			rwait_r <= rwait_nxt;
		end
	end

	// ==========================================================
	// radio and forwarding outputs, all from flip-flops
	wire key_nxt = ph_nxt == trs_pkg::PH_CARR || ph_nxt == trs_pkg::PH_TONE
		|| ph_nxt == trs_pkg::PH_DATA || ph_nxt == trs_pkg::PH_TAIL;
	wire pwr_nxt = (pwr_mode == trs_pkg::PWR_ALWAYS) || ph_nxt != trs_pkg::PH_IDLE; // see [RULE18]
	wire hop_live = fwd_hop_in != trs_pkg::HOP_EXPIRED;
	wire allow_nxt = fwd_remote && ((hop_cfg == trs_pkg::HOP_UNLIMITED)
		|| hop_live); // see [RULE2]
	wire [2:0] hop_nxt = (hop_cfg == trs_pkg::HOP_UNLIMITED) ? fwd_hop_in
		: (hop_live ? fwd_hop_in - 3'h1 : fwd_hop_in);

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			radio_pwr <= 1'b0;
			radio_key <= 1'b0;
			radio_tone <= 1'b0;
			data_go <= 1'b0;
			clock_status <= 1'b0;
			fwd_allow <= 1'b0;
			fwd_hop_out <= 3'h0;
			fwd_append_id <= 1'b0;
			own_src_id <= trs_pkg::RST_SRC_ID;
			add_dest <= 1'b0;
			stamp_readings <= 1'b0;
			fec_mode <= trs_pkg::FEC_STRONG;
		end
		else
		begin
			radio_pwr <= pwr_nxt;
			radio_key <= key_nxt;
			radio_tone <= ph_nxt == trs_pkg::PH_TONE;
			data_go <= ph_nxt == trs_pkg::PH_DATA;
			clock_status <= use_slot; // see [RULE14]
			fwd_allow <= allow_nxt;
			fwd_hop_out <= hop_nxt;
			fwd_append_id <= allow_nxt && ctrl_r[trs_pkg::CTRL_PATH_BIT]; // see [RULE4]
			own_src_id <= src_r;
			add_dest <= ctrl_r[trs_pkg::CTRL_DST_BIT]; // see [RULE3]
			stamp_readings <= slotted; // see [RULE7]
			fec_mode <= ctrl_r[trs_pkg::CTRL_FEC_LSB +: 2]; // see [RULE5]
		end
	end

	// ==========================================================
	// read-back, one cycle after the strobe; unmapped reads return zero
	logic [31:0] rd_mux;
	always_comb
	begin
		case (reg_addr)
			trs_pkg::REG_CTRL: rd_mux = {21'h0, ctrl_r};
			trs_pkg::REG_SRC: rd_mux = {16'h0, src_r};
			trs_pkg::REG_FRAME: rd_mux = {10'h0, frame_r};
			trs_pkg::REG_SLOT: rd_mux = {18'h0, slot_r};
			trs_pkg::REG_OFFSET: rd_mux = {10'h0, offs_r};
			trs_pkg::REG_PAD: rd_mux = {16'h0, pad_r};
			trs_pkg::REG_WARM: rd_mux = {16'h0, warm_r};
			trs_pkg::REG_CARR: rd_mux = {16'h0, carr_r};
			trs_pkg::REG_TONE: rd_mux = {16'h0, tone_r};
			trs_pkg::REG_TAIL: rd_mux = {16'h0, tail_r};
			trs_pkg::REG_STATUS: rd_mux = {20'h0, slot_fits, rej_r, use_slot, good_s2_r, 1'b0, ph_r};
			default: rd_mux = 32'h0;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			reg_rdata <= 32'h0;
		else
			reg_rdata <= reg_rd ? rd_mux : 32'h0;
	end

endmodule

`default_nettype wire

// [test/trs_scheduler_monitor.sv]
// checker for the transmit scheduler: timing and value relations at the top-level ports
// assumes one clock domain, clk_sys, with the active-high asynchronous reset rst
`timescale 1ns/1ns
`default_nettype none

module trs_scheduler_monitor (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic fwd_remote,
	input wire logic [2:0] fwd_hop_in,
	input wire logic fwd_allow,
	input wire logic [2:0] fwd_hop_out,
	input wire logic [15:0] own_src_id,
	input wire logic [1:0] fec_mode,
	input wire logic stamp_readings,
	input wire logic clock_status,
	input wire logic data_go,
	input wire logic radio_pwr,
	input wire logic radio_key,
	input wire logic radio_tone
);
	// ==========================================
	// clocking
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);

	// ==========================================
	// register port and settings
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data not zero outside read answer");
	a_src_range: assert property (own_src_id >= trs_pkg::SRC_ID_MIN
		&& own_src_id <= trs_pkg::SRC_ID_MAX)
		else $error("source id out of range");
	a_fec_code: assert property (fec_mode <= trs_pkg::FEC_WEAK)
		else $error("correction mode beyond weakest");
	a_stamp_status: assert property (!stamp_readings |-> !clock_status)
		else $error("clock status high with slotted mode off");

	// ==========================================
	// forwarding, outputs lag inputs by one cycle
	a_fwd_cause: assert property (fwd_allow |-> $past(fwd_remote))
		else $error("forward without offered packet");
	a_fwd_dec: assert property (fwd_allow && fwd_hop_out != $past(fwd_hop_in)
		|-> fwd_hop_out == $past(fwd_hop_in) - 3'h1)
		else $error("hop count not decremented by one");

	// ==========================================
	// keying phases
	a_key_pwr: assert property (radio_key |-> radio_pwr)
		else $error("carrier keyed without supply");
	a_tone_key: assert property (radio_tone |-> radio_key && !data_go)
		else $error("tone outside keyed carrier");
	a_data_key: assert property (data_go |-> radio_key && !radio_tone)
		else $error("data without plain carrier");
	a_carr_first: assert property ($rose(radio_key) |-> !radio_tone [*8])
		else $error("tone too soon after keying");
	a_data_after_tone: assert property ($rose(data_go) |-> $past(radio_tone))
		else $error("data did not follow tone");
	a_tail: assert property ($fell(data_go) |-> radio_key [*8])
		else $error("carrier dropped without tail");
endmodule

bind trs_scheduler trs_scheduler_monitor u_mon (
	.clk_sys(clk_sys),
	.rst(rst),
	.reg_rd(reg_rd),
	.reg_rdata(reg_rdata),
	.fwd_remote(fwd_remote),
	.fwd_hop_in(fwd_hop_in),
	.fwd_allow(fwd_allow),
	.fwd_hop_out(fwd_hop_out),
	.own_src_id(own_src_id),
	.fec_mode(fec_mode),
	.stamp_readings(stamp_readings),
	.clock_status(clock_status),
	.data_go(data_go),
	.radio_pwr(radio_pwr),
	.radio_key(radio_key),
	.radio_tone(radio_tone)
);

`default_nettype wire

// [test/trs_radio_model.sv]
// behavioural transmit-only radio at the far side of the keying outputs
// assumes the scheduler drives supply, key and tone on clk_sys
`timescale 1ns/1ns
`default_nettype none

module trs_radio_model (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic radio_pwr,
	input wire logic radio_key,
	input wire logic radio_tone,
	output logic rf_on,
	output logic key_unpowered,
	output int warm_cyc
);
	// ==========================================
	// supply time before keying; a cold radio would splatter, so the count is exposed
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			warm_cyc <= 0;
			key_unpowered <= 1'b0;
		end
		else
		begin
			if (!radio_pwr)
				warm_cyc <= 0;
			else if (!radio_key)
				warm_cyc <= warm_cyc + 1;
			if (radio_key && !radio_pwr)
				key_unpowered <= 1'b1;
		end
	end

	// carrier radiates only when keyed and supplied; tone only modulates it
	assign rf_on = radio_pwr & radio_key;
endmodule

`default_nettype wire

// [test/trs_scheduler_tb_top.sv]
// self-checking bench for the transmit scheduler with a behavioural radio
// assumes CYC_MS is shortened to 4 cycles per ms so that warm-up and frames stay short
`timescale 1ns/1ns
`default_nettype none

module trs_scheduler_tb_top;
	localparam int CM = 4;
	logic clk_sys, rst, reg_wr, reg_rd, pps, clock_good, tx_pending, data_done, fwd_remote;
	logic [3:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, q;
	logic [15:0] rand_ms, tx_len_ms, own_src_id;
	logic [2:0] fwd_hop_in, fwd_hop_out;
	logic [1:0] fec_mode;
	logic data_go, fwd_allow, fwd_append_id, add_dest, stamp_readings;
	logic radio_pwr, radio_key, radio_tone, clock_status, rf_on, key_unpowered;
	int warm_cyc, err_count, tests_run, cyc, tk, t0;

	trs_scheduler #(.CYC_MS(CM)) dut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.pps(pps), .clock_good(clock_good), .rand_ms(rand_ms), .tx_pending(tx_pending),
		.tx_len_ms(tx_len_ms), .data_done(data_done), .data_go(data_go),
		.fwd_remote(fwd_remote), .fwd_hop_in(fwd_hop_in), .fwd_allow(fwd_allow),
		.fwd_hop_out(fwd_hop_out), .fwd_append_id(fwd_append_id), .own_src_id(own_src_id),
		.add_dest(add_dest), .stamp_readings(stamp_readings), .fec_mode(fec_mode),
		.radio_pwr(radio_pwr), .radio_key(radio_key), .radio_tone(radio_tone),
		.clock_status(clock_status));
	trs_radio_model u_radio (.clk_sys(clk_sys), .rst(rst), .radio_pwr(radio_pwr),
		.radio_key(radio_key), .radio_tone(radio_tone), .rf_on(rf_on),
		.key_unpowered(key_unpowered), .warm_cyc(warm_cyc));

	// ==========================================
	// clock and cycle count
	initial
	begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	always @(posedge clk_sys) cyc <= cyc + 1;

	// ==========================================
	// shared tasks
	task automatic report_and_stop();
		if (err_count == 0 && tests_run > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input logic ok, input string msg);
		tests_run++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge clk_sys);
		reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [3:0] a);
		@(posedge clk_sys);
		reg_rd <= 1'b1; reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 q = reg_rdata;
	endtask
	function automatic logic sel(input int w);
		case (w)
			0: return radio_pwr;
			1: return radio_key;
			default: return radio_tone;
		endcase
	endfunction
	// bounded wait for a keying output to reach a level; returns the cycle number
	task automatic wait_lvl(input int w, input logic lvl, input int lim, output int t);
		int n;
		for (n = 0; n < lim && sel(w) !== lvl; n++)
		begin
			@(posedge clk_sys);
			#1;
		end
		t = cyc;
		if (sel(w) !== lvl)
		begin
			chk(1'b0, "wait ran out");
			report_and_stop();
		end
	endtask
	// one whole keying sequence; records supply rise and carrier rise
	task automatic run_tx();
		int tt, tf, te, tp;
		@(posedge clk_sys);
		tx_pending <= 1'b1;
		wait_lvl(0, 1'b1, 5, t0);
		wait_lvl(1, 1'b1, 31000, tk);
		chk(warm_cyc >= 750 * CM, "warm-up too short");
		chk(rf_on === 1'b1, "carrier not radiated");
		wait_lvl(2, 1'b1, 200, tt);
		chk(tt - tk >= 5 * CM - 3 && tt - tk <= 5 * CM + 3, "carrier time");
		wait_lvl(2, 1'b0, 400, tf);
		chk(tf - tt >= 55 * CM - 4 && tf - tt <= 55 * CM + 4, "tone time");
		chk(data_go === 1'b1, "data not after tone");
		repeat (8) @(posedge clk_sys);
		data_done <= 1'b1;
		tx_pending <= 1'b0;
		@(posedge clk_sys);
		data_done <= 1'b0;
		tp = cyc;
		wait_lvl(1, 1'b0, 200, te);
		chk(te - tp >= 5 * CM - 5 && te - tp <= 5 * CM + 5, "tail time");
		wait_lvl(0, 1'b0, 40, tp);
		chk(key_unpowered === 1'b0 && rf_on === 1'b0, "radio keyed unpowered");
	endtask

	// ==========================================
	// scenarios
	task automatic t_reset();
		logic [31:0] ev[10] = '{32'h0C1, 32'd1000, 32'd15000, 32'd1000, 32'd0,
			32'd25, 32'd750, 32'd5, 32'd55, 32'd5};
		chk(own_src_id === 16'h03E8 && fec_mode === 2'h0, "reset outputs");
		chk(stamp_readings === 1'b0 && radio_pwr === 1'b0, "reset outputs low");
		for (int i = 0; i < 10; i++)
		begin
			rd(4'(i));
			chk(q === ev[i], "register reset value");
		end
		chk(stamp_readings === 1'b1, "slotted after reset");
		rd(4'hF);
		chk(q === 32'h0, "unmapped read");
	endtask
	task automatic t_refuse();
		logic [3:0] ta[14] = '{1, 1, 1, 1, 2, 2, 2, 2, 2, 3, 3, 3, 0, 4};
		logic [31:0] td[14] = '{0, 65502, 65501, 1, 5100, 3600250, 7000, 3600000,
			5000, 249, 10001, 10000, 32'h059, 5000};
		logic ok[14] = '{0, 0, 1, 1, 0, 0, 0, 1, 1, 0, 0, 1, 0, 0};
		logic [31:0] sh[5] = '{32'h0C1, 32'd1000, 32'd15000, 32'd1000, 32'd0};
		rd(trs_pkg::REG_STATUS);
		for (int i = 0; i < 14; i++)
		begin
			wr(ta[i], td[i]);
			if (ok[i])
				sh[ta[i]] = td[i];
			rd(trs_pkg::REG_STATUS);
			chk(q[10] === ~ok[i], "reject flag");
			rd(ta[i]);
			chk(q === sh[ta[i]], "value after write");
		end
		chk(own_src_id === 16'h0001, "source id output");
		chk(fec_mode === 2'h0, "bad mode dropped");
	endtask
	task automatic t_fwd();
		logic [31:0] cf[4] = '{32'h041, 32'h041, 32'h047, 32'h001};
		logic [2:0] hi[4] = '{0, 3, 3, 3};
		logic [4:0] ex[4] = '{5'b00000, 5'b11010, 5'b11011, 5'b10010};
		for (int i = 0; i < 4; i++)
		begin
			wr(trs_pkg::REG_CTRL, cf[i]);
			fwd_remote <= 1'b1;
			fwd_hop_in <= hi[i];
			@(posedge clk_sys);
			@(posedge clk_sys);
			#1;
			chk({fwd_allow, fwd_append_id, fwd_hop_out} === ex[i], "forwarding");
			fwd_remote <= 1'b0;
		end
	endtask
	task automatic t_opts();
		for (int m = 0; m < 3; m++)
		begin
			wr(trs_pkg::REG_CTRL, 32'h061 | (m << 3));
			@(posedge clk_sys);
			#1;
			chk(fec_mode === 2'(m) && add_dest === 1'b1, "mode and dest");
		end
		chk(stamp_readings === 1'b0 && clock_status === 1'b0, "unslotted");
		wr(trs_pkg::REG_CTRL, 32'h241);
		repeat (3) @(posedge clk_sys);
		#1;
		chk(radio_pwr === 1'b1 && add_dest === 1'b0, "power always");
		wr(trs_pkg::REG_CTRL, 32'h041);
		repeat (3) @(posedge clk_sys);
		#1;
		chk(radio_pwr === 1'b0, "power with data only");
	endtask
	task automatic t_unslot();
		rand_ms <= 16'd3;
		run_tx();
		chk(tk - t0 >= 753 * CM - 2 && tk - t0 <= 753 * CM + 10, "random start");
	endtask
	task automatic t_slot();
		int tp, tc;
		wr(trs_pkg::REG_CTRL, 32'h0C1);
		wr(trs_pkg::REG_PAD, 32'd40);
		clock_good <= 1'b1;
		@(posedge clk_sys);
		pps <= 1'b1;
		tp = cyc + 1;
		repeat (10) @(posedge clk_sys);
		pps <= 1'b0;
		repeat (4) @(posedge clk_sys);
		#1;
		chk(clock_status === 1'b1, "assured status");
		run_tx();
		chk((tk - tp) % (1000 * CM) >= 40 * CM
			&& (tk - tp) % (1000 * CM) <= 40 * CM + 4, "slot start");
		// centred: keyed time is data 20 plus carrier 5, tone 55 and tail 5 ms
		tc = (1000 - 20 - 5 - 55 - 5) / 2 * CM;
		wr(trs_pkg::REG_SLOT, 32'd1000);
		wr(trs_pkg::REG_CTRL, 32'h1C1);
		run_tx();
		chk((tk - tp) % (1000 * CM) >= tc
			&& (tk - tp) % (1000 * CM) <= tc + 4, "centered start");
		clock_good <= 1'b0;
		repeat (5) @(posedge clk_sys);
		#1;
		chk(clock_status === 1'b0, "status after drift");
	endtask

	// ==========================================
	// main sequence
	initial
	begin
		cyc = 0; err_count = 0; tests_run = 0;
		rst = 1'b1; reg_wr = 1'b0; reg_rd = 1'b0; reg_addr = 4'h0; reg_wdata = 32'h0;
		pps = 1'b0; clock_good = 1'b0; rand_ms = 16'h0; tx_pending = 1'b0;
		tx_len_ms = 16'd20; data_done = 1'b0; fwd_remote = 1'b0; fwd_hop_in = 3'h0;
		repeat (2) @(posedge clk_sys);
		rst <= 1'b0;
		#1;
		t_reset();
		t_refuse();
		t_fwd();
		t_opts();
		t_unslot();
		t_slot();
		report_and_stop();
	end
endmodule

`default_nettype wire
